// >>> hw/pwm_pair_pkg.sv
// Constants shared by the paired channel PWM block
package pwm_pair_pkg;
  localparam int          CNT_W          = 16;
  localparam logic [15:0] CNT_ZERO       = 16'h0000;
  localparam logic [15:0] RELOAD_RST     = 16'h0000;
  localparam logic [1:0]  CLK_SEL_A      = 2'h0;
  localparam logic [1:0]  CLK_SEL_B      = 2'h1;
  localparam logic [1:0]  MASTER_CH_0    = 2'h0;
  localparam logic [1:0]  MASTER_CH_2    = 2'h2;
  localparam logic [1:0]  SLAVE_CH_RST   = 2'h1;
  localparam logic        OUT_VALUE_RST  = 1'b0;
  localparam logic        POL_POSITIVE   = 1'b0;
  localparam logic        MODE_SLAVE_OUT = 1'b1;
endpackage

// >>> hw/pwm_down_counter.sv
// One timer channel down counter with reload, used for master and slave
`timescale 1ns/1ps
`default_nettype none
module pwm_down_counter
  import pwm_pair_pkg::*;
#(
  parameter int W = CNT_W
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rst,
  input  wire logic         i_tick,
  input  wire logic         i_run,
  input  wire logic         i_load,
  input  wire logic         i_repeat,
  input  wire logic [W-1:0] i_reload,
  output logic      [W-1:0] o_count,
  output logic              o_zero,
  output logic              o_counting
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         act_r;
  logic         act_nxt;
  logic         zero_nxt;

  // Load wins over counting; stopped channel holds its value
  always_comb begin
    cnt_nxt  = cnt_r;
    act_nxt  = act_r;
    zero_nxt = 1'b0;
    if (i_run && i_load) begin
      cnt_nxt = i_reload;
      act_nxt = 1'b1;
    end else if (i_run && i_tick && act_r) begin
      if (cnt_r == W'(0)) begin
        zero_nxt = 1'b1;
        if (i_repeat) cnt_nxt = i_reload;
        else act_nxt = 1'b0;
      end else begin
        cnt_nxt = cnt_r - W'(1);
      end
    end
    if (!i_run) act_nxt = 1'b0;
  end

  // Registers only
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cnt_r  <= '0;
      act_r  <= 1'b0;
      o_zero <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      act_r  <= act_nxt;
      o_zero <= zero_nxt;
    end
  end

  assign o_count    = cnt_r;
  assign o_counting = act_r;
endmodule
`default_nettype wire

// >>> hw/paired_channel_pwm.sv
// Paired master/slave timer channels producing one PWM output
// What this block does
// R1 - Period is master reload plus one count clocks.
// R2 - Duty is slave reload over master reload plus one.
// R3 - Slave reload zero keeps output inactive all period.
// R4 - Slave reload of master plus one or more gives full duty.
// R5 - Master start raises irq, loads reload, then counts down.
// R6 - Master at zero raises irq, reloads, keeps counting.
// R7 - Master repeats until its stop trigger is written.
// R8 - Master irq loads slave; slave counts to zero, irqs, stops.
// R9 - Output active one count clock after master irq, inactive at slave zero.
// R10 - Software rewrites both reloads right after a master irq.
// R11 - Start bits self clear and set both enable status bits.
// R12 - Stop bits clear enables, freeze counters, output keeps level.
// R13 - Software leaves modes and output setup alone while running.
// R14 - Both counters readable at any time.
// R15 - Direct output value drives pin while counting is not in control.
// R16 - Output enable lets counting drive the output.
// R17 - Polarity bit selects high or low active level.
// R18 - Slave output mode: master irq sets, slave irq clears.
// R19 - Writes refused without unit clock; start stopped once enabled.
// R20 - Clock withdrawal initializes all but the count clock synchronizers; pin reverts to port.
// R21 - Masters are channels 0 or 2; channel 2 only feeds 3.
// R22 - One decrement per count clock edge; irqs are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module paired_channel_pwm
  import pwm_pair_pkg::*;
#(
  parameter int W = CNT_W
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rst,
  input  wire logic         i_unit_clock_enable,
  input  wire logic         i_prescaled_clock_a,
  input  wire logic         i_prescaled_clock_b,
  input  wire logic         i_master_clk_sel,
  input  wire logic         i_slave_clk_sel,
  input  wire logic [1:0]   i_pair_master_select,
  input  wire logic [1:0]   i_slave_channel,
  input  wire logic         i_cfg_write,
  input  wire logic [W-1:0] i_master_reload_value,
  input  wire logic [W-1:0] i_slave_reload_value,
  input  wire logic         i_master_start_trigger,
  input  wire logic         i_slave_start_trigger,
  input  wire logic         i_master_stop_trigger,
  input  wire logic         i_slave_stop_trigger,
  input  wire logic         i_out_value_write,
  input  wire logic         i_out_value,
  input  wire logic         i_slave_output_enable,
  input  wire logic         i_slave_output_polarity,
  input  wire logic         i_slave_output_mode_select,
  output logic [W-1:0]      o_master_down_counter,
  output logic [W-1:0]      o_slave_down_counter,
  output logic              o_master_enable_status,
  output logic              o_slave_enable_status,
  output logic              o_master_period_irq,
  output logic              o_slave_duty_irq,
  output logic              o_pwm_out_pin,
  output logic              o_pin_timer_func,
  output logic              o_pair_valid
);
  // Prescaled clocks come from another divider: two flops then edge detect
  logic [1:0] ca_sync_r;
  logic [1:0] cb_sync_r;
  logic       ca_prev_r;
  logic       cb_prev_r;
  logic       tick_a;
  logic       tick_b;
  logic       master_tick;
  logic       slave_tick;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ca_sync_r <= 2'h0;
      cb_sync_r <= 2'h0;
      ca_prev_r <= 1'b0;
      cb_prev_r <= 1'b0;
    end else begin
      ca_sync_r <= {ca_sync_r[0], i_prescaled_clock_a};
      cb_sync_r <= {cb_sync_r[0], i_prescaled_clock_b};
      ca_prev_r <= ca_sync_r[1];
      cb_prev_r <= cb_sync_r[1];
    end
  end

  // One tick per rising edge of the selected count clock
  assign tick_a      = ca_sync_r[1] & ~ca_prev_r; // R22
  assign tick_b      = cb_sync_r[1] & ~cb_prev_r; // R22
  assign master_tick = (i_master_clk_sel == CLK_SEL_B[0]) ? tick_b : tick_a;
  assign slave_tick  = (i_slave_clk_sel == CLK_SEL_B[0]) ? tick_b : tick_a;

  // Unit reset: external reset or clock withdrawn
  logic unit_rst;
  assign unit_rst = i_rst | ~i_unit_clock_enable; // R20

  // Configuration registers, writable only with the unit clock supplied
  logic [W-1:0] mreload_r;
  logic [W-1:0] mreload_nxt;
  logic [W-1:0] sreload_r;
  logic [W-1:0] sreload_nxt;
  logic [1:0]   msel_r;
  logic [1:0]   msel_nxt;
  logic [1:0]   schan_r;
  logic [1:0]   schan_nxt;
  logic         outval_r;
  logic         outval_nxt;
  logic         pair_ok;

  always_comb begin
    mreload_nxt = mreload_r;
    sreload_nxt = sreload_r;
    msel_nxt    = msel_r;
    schan_nxt   = schan_r;
    outval_nxt  = outval_r;
    if (i_cfg_write) begin // R19
      mreload_nxt = i_master_reload_value;
      sreload_nxt = i_slave_reload_value;
      msel_nxt    = i_pair_master_select;
      schan_nxt   = i_slave_channel;
    end
    if (i_out_value_write) outval_nxt = i_out_value; // R15
  end

  always_ff @(posedge i_mclk) begin
    if (unit_rst) begin // R19 R20
      mreload_r <= RELOAD_RST;
      sreload_r <= RELOAD_RST;
      msel_r    <= MASTER_CH_0;
      schan_r   <= SLAVE_CH_RST;
      outval_r  <= OUT_VALUE_RST;
    end else begin
      mreload_r <= mreload_nxt;
      sreload_r <= sreload_nxt;
      msel_r    <= msel_nxt;
      schan_r   <= schan_nxt;
      outval_r  <= outval_nxt;
    end
  end

  // Legal pairs only: 0 feeds 1..3, 2 feeds 3 alone
  assign pair_ok = ((msel_r == MASTER_CH_0) && (schan_r != MASTER_CH_0)) ||
                   ((msel_r == MASTER_CH_2) && (schan_r == 2'h3)); // R21

  // Channel run state; start and stop bits are pulses, so they self clear
  typedef enum logic [1:0] {
    ST_STOP = 2'b01,
    ST_RUN  = 2'b10
  } run_state_t;

  run_state_t mst_r;
  run_state_t mst_nxt;
  run_state_t sst_r;
  run_state_t sst_nxt;
  logic       mstart_pend_r;
  logic       mstart_pend_nxt;

  always_comb begin
    mst_nxt         = mst_r;
    sst_nxt         = sst_r;
    mstart_pend_nxt = 1'b0;
    case (mst_r)
      ST_STOP: begin
        if (i_master_start_trigger && pair_ok) begin // R11 R21
          mst_nxt         = ST_RUN;
          mstart_pend_nxt = 1'b1; // R5
        end
      end
      ST_RUN: begin
        if (i_master_stop_trigger) mst_nxt = ST_STOP; // R7 R12
      end
      default: mst_nxt = ST_STOP;
    endcase
    case (sst_r)
      ST_STOP: begin
        if (i_slave_start_trigger && pair_ok) sst_nxt = ST_RUN; // R11
      end
      ST_RUN: begin
        if (i_slave_stop_trigger) sst_nxt = ST_STOP; // R12
      end
      default: sst_nxt = ST_STOP;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (unit_rst) begin // R19
      mst_r         <= ST_STOP;
      sst_r         <= ST_STOP;
      mstart_pend_r <= 1'b0;
    end else begin
      mst_r         <= mst_nxt;
      sst_r         <= sst_nxt;
      mstart_pend_r <= mstart_pend_nxt;
    end
  end

  // Master irq: at start and each time the master counter expires
  logic         m_run;
  logic         s_run;
  logic         m_zero;
  logic         s_zero;
  logic         m_irq;
  logic [W-1:0] m_cnt;
  logic [W-1:0] s_cnt;
  logic         s_act;
  logic         s_expire;

  assign m_run = (mst_r == ST_RUN);
  assign s_run = (sst_r == ST_RUN);
  assign m_irq = mstart_pend_r | m_zero; // R5 R6

  // Master in interval mode, repeating reload
  pwm_down_counter #(.W(W)) u_master (
    .i_mclk     (i_mclk),
    .i_rst      (unit_rst),
    .i_tick     (master_tick),
    .i_run      (m_run),
    .i_load     (mstart_pend_r),
    .i_repeat   (1'b1),
    .i_reload   (mreload_r),
    .o_count    (m_cnt),
    .o_zero     (m_zero),
    .o_counting ()
  ); // R1 R5 R6 R7

  // Slave in single count mode, retriggered by every master irq
  pwm_down_counter #(.W(W)) u_slave (
    .i_mclk     (i_mclk),
    .i_rst      (unit_rst),
    .i_tick     (slave_tick),
    .i_run      (s_run),
    .i_load     (m_irq),
    .i_repeat   (1'b0),
    .i_reload   (sreload_r),
    .o_count    (s_cnt),
    .o_zero     (s_zero),
    .o_counting (s_act)
  ); // R8 R2

  // Slave expiry taken on the tick itself: the registered zero flag lands a cycle
  // late and would stretch the active time and collide with the next master irq
  assign s_expire = s_run && s_act && slave_tick && !m_irq && (s_cnt == '0); // R3 R9

  // Output level: set one count clock after master irq, cleared at slave zero.
  // Zero reload means the slave expires on that same tick, so the set never shows.
  logic set_pend_r;
  logic set_pend_nxt;
  logic act_r;
  logic act_nxt;
  logic counting_drives;

  assign counting_drives = i_slave_output_enable && (i_slave_output_mode_select == MODE_SLAVE_OUT); // R16 R18

  always_comb begin
    set_pend_nxt = set_pend_r;
    act_nxt      = act_r;
    if (m_irq && s_run) set_pend_nxt = 1'b1;
    if (s_expire) begin
      act_nxt      = 1'b0; // R9 R18
      set_pend_nxt = 1'b0; // R3
    end else if (set_pend_r && slave_tick && !m_irq) begin
      act_nxt      = 1'b1; // R9
      set_pend_nxt = 1'b0;
    end
    // A slave reload past the period is reloaded before zero: stays active
    if (!s_run) set_pend_nxt = 1'b0; // R4 R12
  end

  always_ff @(posedge i_mclk) begin
    if (unit_rst) begin
      set_pend_r <= 1'b0;
      act_r      <= 1'b0;
    end else begin
      set_pend_r <= set_pend_nxt;
      act_r      <= act_nxt;
    end
  end

  // Pin value; counting only overwrites the held value when enabled and running
  logic pin_nxt;
  always_comb begin
    pin_nxt = o_pwm_out_pin;
    if (i_out_value_write) pin_nxt = i_out_value; // R15
    else if (counting_drives && s_run) pin_nxt = act_nxt ^ i_slave_output_polarity; // R16 R17 R12
    else if (!counting_drives) pin_nxt = outval_nxt; // R15
  end

  // Registered outputs
  always_ff @(posedge i_mclk) begin
    if (unit_rst) begin // R20
      o_master_down_counter  <= '0;
      o_slave_down_counter   <= '0;
      o_master_enable_status <= 1'b0;
      o_slave_enable_status  <= 1'b0;
      o_master_period_irq    <= 1'b0;
      o_slave_duty_irq       <= 1'b0;
      o_pwm_out_pin          <= OUT_VALUE_RST;
      o_pin_timer_func       <= 1'b0;
      o_pair_valid           <= 1'b0;
    end else begin
      o_master_down_counter  <= m_cnt; // R14
      o_slave_down_counter   <= s_cnt; // R14
      o_master_enable_status <= (mst_nxt == ST_RUN); // R11 R12
      o_slave_enable_status  <= (sst_nxt == ST_RUN); // R11 R12
      o_master_period_irq    <= m_irq; // R22
      o_slave_duty_irq       <= s_zero; // R8 R22
      o_pwm_out_pin          <= pin_nxt;
      o_pin_timer_func       <= 1'b1;
      o_pair_valid           <= pair_ok;
    end
  end
endmodule
`default_nettype wire

// >>> dv/pwm_load_model.sv
// Load on the PWM pin: measures period and high time between marks
`timescale 1ns/1ps
`default_nettype none
module pwm_load_model (
  input  wire logic        i_mclk,
  input  wire logic        i_pin,
  input  wire logic        i_mark,
  output logic      [15:0] o_period,
  output logic      [15:0] o_high
);
  logic [15:0] cnt_r;
  logic [15:0] high_r;
  // Window restarts at each mark; any phase of a periodic pin gives one count
  always_ff @(posedge i_mclk) begin
    if (i_mark) begin
      o_period <= cnt_r;
      o_high   <= high_r;
      cnt_r    <= 16'h0001;
      high_r   <= {15'h0000, i_pin};
    end else begin
      cnt_r  <= cnt_r + 16'h0001;
      high_r <= high_r + {15'h0000, i_pin};
    end
  end
endmodule
`default_nettype wire

// >>> dv/paired_channel_pwm_chk.sv
// Port checker for the paired channel PWM block
`timescale 1ns/1ps
`default_nettype none
module paired_channel_pwm_chk
  import pwm_pair_pkg::*;
#(
  parameter int W = CNT_W
) (
  input wire logic         i_mclk,
  input wire logic         i_rst,
  input wire logic         i_unit_clock_enable,
  input wire logic         i_master_start_trigger,
  input wire logic         i_slave_start_trigger,
  input wire logic         i_master_stop_trigger,
  input wire logic         i_slave_stop_trigger,
  input wire logic         i_out_value_write,
  input wire logic         i_out_value,
  input wire logic         i_slave_output_polarity,
  input wire logic [W-1:0] o_master_down_counter,
  input wire logic [W-1:0] o_slave_down_counter,
  input wire logic         o_master_enable_status,
  input wire logic         o_slave_enable_status,
  input wire logic         o_master_period_irq,
  input wire logic         o_slave_duty_irq,
  input wire logic         o_pwm_out_pin,
  input wire logic         o_pin_timer_func,
  input wire logic         o_pair_valid
);
  default clocking dc @(posedge i_mclk); endclocking
  default disable iff (i_rst || !i_unit_clock_enable);
  // Both start bits on a legal, idle pair
  sequence start_s;
    i_master_start_trigger && i_slave_start_trigger && !i_master_stop_trigger && o_pair_valid && !o_master_enable_status;
  endsequence
  // Master stopped long enough for pending ticks to drain
  sequence idle_s;
    !o_master_enable_status [*4];
  endsequence
  master_pulse_a: assert property (o_master_period_irq |=> !o_master_period_irq)
    else $error("master irq wider than one cycle");
  slave_pulse_a: assert property (o_slave_duty_irq |=> !o_slave_duty_irq)
    else $error("slave irq wider than one cycle");
  start_run_a: assert property (start_s |=> o_master_enable_status && o_slave_enable_status ##1 o_master_period_irq)
    else $error("start did not enable both and raise master irq");
  stop_run_a: assert property (i_master_stop_trigger && i_slave_stop_trigger |=> !o_master_enable_status && !o_slave_enable_status)
    else $error("stop did not clear enables");
  counter_freeze_a: assert property (idle_s |-> $stable(o_master_down_counter) && $stable(o_slave_down_counter))
    else $error("counter moved while stopped");
  idle_quiet_a: assert property (idle_s |-> !o_master_period_irq && !o_slave_duty_irq)
    else $error("irq while stopped");
  pin_hold_a: assert property ((!o_master_enable_status && !i_out_value_write && $stable(i_slave_output_polarity)) [*4] |-> $stable(o_pwm_out_pin))
    else $error("pin changed while stopped");
  direct_value_a: assert property (i_out_value_write |=> o_pwm_out_pin == $past(i_out_value))
    else $error("direct value not on pin");
  unit_reset_a: assert property (disable iff (i_rst) !i_unit_clock_enable |=> !o_pin_timer_func && !o_pwm_out_pin && !o_master_enable_status)
    else $error("unit clock off did not initialize");
endmodule
bind paired_channel_pwm paired_channel_pwm_chk #(.W(W)) chk_i (.*);
`default_nettype wire

// >>> dv/paired_channel_pwm_bench.sv
// Random and corner-case bench for the paired channel PWM block
`timescale 1ns/1ps
`default_nettype none
module paired_channel_pwm_bench;
  import pwm_pair_pkg::*;
  logic i_mclk = 1'b0, i_rst = 1'b1, i_unit_clock_enable = 1'b0, i_prescaled_clock_a = 1'b0;
  logic i_prescaled_clock_b = 1'b0, i_master_clk_sel = 1'b0, i_slave_clk_sel = 1'b0, i_cfg_write = 1'b0;
  logic i_master_start_trigger = 1'b0, i_slave_start_trigger = 1'b0, i_master_stop_trigger = 1'b0;
  logic i_slave_stop_trigger = 1'b0, i_out_value_write = 1'b0, i_out_value = 1'b0, i_slave_output_enable = 1'b0;
  logic i_slave_output_polarity = 1'b0, i_slave_output_mode_select = MODE_SLAVE_OUT;
  logic [1:0]  i_pair_master_select = 2'h0, i_slave_channel = 2'h1, ms, sc;
  logic [15:0] i_master_reload_value = 16'h0000, i_slave_reload_value = 16'h0000;
  logic [15:0] o_master_down_counter, o_slave_down_counter, per, hi, m, s, t, a;
  logic o_master_enable_status, o_slave_enable_status, o_master_period_irq, o_slave_duty_irq;
  logic o_pwm_out_pin, o_pin_timer_func, o_pair_valid, pol, oe, md, p;
  logic [2:0]  pc = 3'h0;
  logic [31:0] seed = 32'h9548_0fab;
  int failures = 0, comparisons = 0;
  paired_channel_pwm uut (.*);
  pwm_load_model load (.i_mclk(i_mclk), .i_pin(o_pwm_out_pin), .i_mark(o_master_period_irq), .o_period(per), .o_high(hi));
  initial begin
    forever #12.5 i_mclk = ~i_mclk;
  end
  // Count clocks: a ticks every 4 cycles, b every 8
  always @(posedge i_mclk) begin
    pc <= pc + 3'h1;
    i_prescaled_clock_a <= pc[1];
    i_prescaled_clock_b <= pc[2];
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // High cycles per period; duty saturates once slave exceeds master
  function automatic logic [15:0] exp_hi();
    logic [15:0] d;
    d = !(oe && md) ? 16'h0000 : (s > m ? m + 16'h0001 : s);
    return (pol && oe && md) ? (m + 16'h0001 - d) * t : d * t;
  endfunction
  task automatic wrap_up;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded wait for a master irq, sampled at the falling edge
  task automatic wait_irq;
    int n;
    n = 0;
    do begin
      @(negedge i_mclk);
      n++;
    end while (o_master_period_irq !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      failures++;
      wrap_up;
    end
  endtask
  task automatic cfg;
    @(posedge i_mclk);
    i_master_reload_value <= m;
    i_slave_reload_value <= s;
    i_pair_master_select <= ms;
    i_slave_channel <= sc;
    i_cfg_write <= 1'b1;
    @(posedge i_mclk);
    i_cfg_write <= 1'b0;
  endtask
  task automatic trig(input logic st, input logic sp);
    @(posedge i_mclk);
    {i_master_start_trigger, i_slave_start_trigger} <= {st, st};
    {i_master_stop_trigger, i_slave_stop_trigger} <= {sp, sp};
    @(posedge i_mclk);
    {i_master_start_trigger, i_slave_start_trigger, i_master_stop_trigger, i_slave_stop_trigger} <= 4'h0;
  endtask
  // Output setup only changes with the unit clock withdrawn
  task automatic unit_reset;
    @(posedge i_mclk);
    i_unit_clock_enable <= 1'b0;
    i_slave_output_polarity <= pol;
    i_slave_output_enable <= oe;
    i_slave_output_mode_select <= md;
    {i_master_clk_sel, i_slave_clk_sel} <= {t[3], t[3]};
    @(posedge i_mclk);
    i_unit_clock_enable <= 1'b1;
  endtask
  // Skip one period so the load sees a settled waveform
  task automatic measure;
    repeat (3) wait_irq;
    check(16'((o_master_down_counter <= m) && (o_slave_down_counter <= s)), 16'h0001);
    @(negedge i_mclk);
    check(per, (m + 16'h0001) * t);
    check(hi, exp_hi());
  endtask
  initial begin
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    i_unit_clock_enable <= 1'b1;
    @(negedge i_mclk);
    check({15'h0000, o_pin_timer_func}, 16'h0000);
    m = 16'h0005;
    s = 16'h0002;
    for (int k = 0; k < 16; k++) begin
      {ms, sc} = 4'(k);
      p = (ms == MASTER_CH_0 && sc != 2'h0) || (ms == MASTER_CH_2 && sc == 2'h3);
      cfg;
      trig(1'b1, 1'b0);
      @(negedge i_mclk);
      check({14'h0000, o_pair_valid, o_master_enable_status}, {14'h0000, p, p});
      trig(1'b0, 1'b1);
    end
    $display("pair selection test done");
    for (int v = 1; v >= 0; v--) begin
      @(posedge i_mclk);
      i_out_value <= v[0];
      i_out_value_write <= 1'b1;
      @(posedge i_mclk);
      i_out_value_write <= 1'b0;
      @(negedge i_mclk);
      check({15'h0000, o_pwm_out_pin}, 16'(v));
    end
    $display("direct value test done");
    for (int c = 0; c < 7; c++) begin
      seed = lfsr(seed);
      m = 16'h0002 + 16'(seed[2:0]);
      s = (c == 0) ? 16'h0000 : (c == 1) ? m : (c == 2) ? m + 16'h0001 : (c == 3) ? m + 16'h0005 : 16'(seed[6:3]);
      pol = seed[7];
      oe = (c != 5);
      md = (c != 6);
      t = seed[9] ? 16'h0008 : 16'h0004;
      ms = seed[10] ? MASTER_CH_2 : MASTER_CH_0;
      sc = ms[1] ? 2'h3 : (seed[12:11] == 2'h0 ? 2'h1 : seed[12:11]);
      unit_reset;
      cfg;
      trig(1'b1, 1'b0);
      @(negedge i_mclk);
      check({13'h0000, o_pin_timer_func, o_master_enable_status, o_slave_enable_status}, 16'h0007);
      measure;
      seed = lfsr(seed);
      s = 16'(seed[3:0]);
      wait_irq;
      cfg;
      measure;
      trig(1'b0, 1'b1);
      repeat (4) @(negedge i_mclk);
      check({14'h0000, o_master_enable_status, o_slave_enable_status}, 16'h0000);
      a = o_master_down_counter;
      p = o_pwm_out_pin;
      repeat (12) @(negedge i_mclk);
      check(o_master_down_counter, a);
      check({15'h0000, o_pwm_out_pin}, {15'h0000, p});
      $display("pwm case %0d done, period %0d high %0d", c, per, hi);
    end
    wrap_up;
  end
endmodule
`default_nettype wire
